// [include/ssrr_pkg.sv]
`default_nettype none
package ssrr_pkg;
    // Frame limits and field positions
    localparam int MAX_FRAME = 41;           // Longest legal command frame in bytes
    localparam int REG_COUNT = 16;           // Reference words 0 to 15
    localparam logic [7:0] BCAST_ADDR = 8'h00;
    localparam logic [7:0] FUNC_READ = 8'h03;
    localparam logic [7:0] FUNC_WRITE = 8'h10;
    localparam logic [7:0] FUNC_ERR_BIT = 8'h80;
    localparam logic [7:0] EC_FUNC = 8'h01;  // Unsupported function
    localparam logic [7:0] EC_ADDR = 8'h02;  // Register range error
    localparam logic [7:0] EC_DATA = 8'h03;  // Quantity or length error
    localparam logic [5:0] POS_ADDR = 6'h00;
    localparam logic [5:0] POS_FUNC = 6'h01;
    localparam logic [5:0] POS_START_HI = 6'h02;
    localparam logic [5:0] POS_START_LO = 6'h03;
    localparam logic [5:0] POS_QTY_HI = 6'h04;
    localparam logic [5:0] POS_QTY_LO = 6'h05;
    localparam logic [5:0] POS_BCOUNT = 6'h06;
    localparam logic [5:0] POS_WDATA = 6'h07;
    localparam logic [5:0] POS_RDATA = 6'h03;  // First data byte of a read answer
    localparam logic [5:0] MIN_FRAME = 6'h04;
    localparam logic [5:0] READ_FRAME = 6'h08;
    localparam logic [5:0] WRITE_OVERHEAD = 6'h09;
    localparam logic [5:0] LEN_WRITE_ANS = 6'h06;
    localparam logic [5:0] LEN_ERR_ANS = 6'h03;
    localparam logic [5:0] LEN_READ_HDR = 6'h03;
    localparam logic [5:0] LEN_CRC = 6'h02;
    // CRC-16 settings
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;
    // Register indices
    localparam logic [3:0] REG_RUN_CMD = 4'h1;
    localparam logic [3:0] REG_SPEED_REF = 4'h2;
    localparam logic [3:0] REG_LOOP_TARGET = 4'h6;
    localparam logic [3:0] REG_AOUT_ONE = 4'h7;
    localparam logic [3:0] REG_AOUT_TWO = 4'h8;
    localparam logic [3:0] REG_DOUT = 4'h9;
    localparam logic [3:0] REG_REF_SELECT = 4'hF;
    localparam logic [15:0] WRITABLE_MASK = 16'h83C6;  // Words 1,2,6,7,8,9,F
    localparam logic [15:0] REG_RESET = 16'h0000;
    // Analog full scale in counts
    localparam logic signed [15:0] AOUT_FULL_SCALE = 16'sh0604;
    // Bit positions
    localparam int RUN_FWD_BIT = 0;
    localparam int RUN_REV_BIT = 1;
    localparam int RUN_EXT_FAULT_BIT = 2;
    localparam int RUN_FAULT_RESET_BIT = 3;
    localparam int RUN_NET_REF_BIT = 4;
    localparam int RUN_COMM_CTRL_BIT = 5;
    localparam int RUN_MF_LO = 6;
    localparam int RUN_MF_HI = 15;
    localparam int DOUT_RELAY_BIT = 0;
    localparam int DOUT_OPTO_LO = 1;
    localparam int DOUT_OPTO_HI = 4;
    localparam int DOUT_FAULT_EN_BIT = 6;
    localparam int DOUT_FAULT_BIT = 7;
    localparam int SEL_LOOP_TARGET_BIT = 1;
    localparam int SEL_BCAST_LO = 12;
    localparam int SEL_BCAST_HI = 15;

    // Decoded reference outputs handed to the drive logic
    typedef struct packed {
        logic fwd_run;
        logic rev_run;
        logic remote_external_fault;
        logic fault_reset;
        logic network_reference_select;
        logic comm_control_select;
        logic [9:0] mf_input_cmd;            // Inputs 3 to 12
        logic [15:0] speed_reference;
        logic [15:0] loop_target_value;
        logic loop_target_enable;
        logic signed [15:0] analog_out_one;
        logic signed [15:0] analog_out_two;
        logic relay_contact_output;
        logic [3:0] photocoupler_output;
        logic fault_relay_contact;
        logic [3:0] broadcast_enable;
    } ssrr_ref_out_s;

    typedef enum {ST_IDLE, ST_CHECK, ST_WRITE, ST_RESP} ssrr_state_e;
    typedef enum {ANS_WRITE, ANS_READ, ANS_ERR} ssrr_ans_e;
endpackage : ssrr_pkg
`default_nettype wire

// [core/ssrr_core.sv]
// Summary of operation
// - Write data arrives high byte, low byte, ascending
// - Write frame fields stored into consecutive registers
// - Byte count must equal twice register quantity
// - Good write echoes address, function, start, quantity
// - Failed write answers 90H plus error code
// - Reference words read back last written value
// - Run word bits 0,1 forward and reverse
// - Run word bits 2,3 fault and reset
// - Bits 4,5 selects; bits 6-F inputs 3-12
// - Speed reference word, unit set externally
// - Loop target used only when select bit1
// - Analog outputs signed, full scale 1540
// - Output word bit0 relay, bits1-4 photocouplers
// - Fault contact follows bit7 while bit6 set
// - Select bits C-F enable broadcast inputs
// - Unused addresses hold nothing, read zero
// - CRC-16 starts all ones, covers whole frame
// - Address zero broadcast: act, never answer
`default_nettype none
module ssrr_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Configuration
    input wire logic [7:0] slave_addr,
    input wire logic drive_fault,
    // Received byte stream from the link receiver
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_frame_end,
    // Transmit byte stream to the link transmitter
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    // Status
    output logic busy,
    // Decoded reference outputs
    output ssrr_pkg::ssrr_ref_out_s ref_out
);
    // Frame and word storage
    ssrr_pkg::ssrr_state_e state;        // Frame handling phase
    ssrr_pkg::ssrr_ans_e ans_kind;       // Kind of answer being sent
    logic [7:0] rx_buf [ssrr_pkg::MAX_FRAME];  // Whole received frame
    logic [15:0] ref_mem [ssrr_pkg::REG_COUNT]; // Reference words
    logic [5:0] rx_len;                  // Bytes caught in this frame
    logic rx_overflow;                   // Frame longer than any legal one
    logic [15:0] rx_crc;                 // Running CRC over received bytes
    logic [15:0] tx_crc;                 // Running CRC over sent bytes
    logic [5:0] tx_idx;                  // Next answer byte position
    logic [5:0] ans_len;                 // Answer bytes before the CRC
    logic [7:0] err_code;                // Error code for a refused command
    logic [4:0] wr_idx;                  // Word index during the write walk
    logic bcast;                         // Current frame is a broadcast

    // One CRC-16 step over a byte, reflected polynomial, LSB first
    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        // Shift once per bit
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ ssrr_pkg::CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc_step

    // Field decode of the held frame
    wire [7:0] f_addr = rx_buf[ssrr_pkg::POS_ADDR];
    wire [7:0] f_func = rx_buf[ssrr_pkg::POS_FUNC];
    wire [15:0] f_start = {rx_buf[ssrr_pkg::POS_START_HI],
        rx_buf[ssrr_pkg::POS_START_LO]};
    wire [15:0] f_qty = {rx_buf[ssrr_pkg::POS_QTY_HI],
        rx_buf[ssrr_pkg::POS_QTY_LO]};
    wire [7:0] f_bcount = rx_buf[ssrr_pkg::POS_BCOUNT];
    wire [16:0] f_end = {1'b0, f_start} + {1'b0, f_qty};
    wire is_write = (f_func == ssrr_pkg::FUNC_WRITE);
    wire is_read = (f_func == ssrr_pkg::FUNC_READ);

    // Residue zero over whole frame
    // Frame acceptance: length, CRC residue and addressing
    wire crc_good = (rx_crc == ssrr_pkg::CRC_RESIDUE);
    wire frame_good = !rx_overflow && (rx_len >= ssrr_pkg::MIN_FRAME) && crc_good;
    wire addr_bcast = (f_addr == ssrr_pkg::BCAST_ADDR);
    wire addressed = (f_addr == slave_addr) || addr_bcast;

    // Quantity and length checks; the count of data bytes is twice the words
    wire qty_good = (f_qty != 16'h0000) && (f_qty <= 16'(ssrr_pkg::REG_COUNT));
    wire range_good = (f_end <= 17'(ssrr_pkg::REG_COUNT));
    wire bcount_good = ({8'h00, f_bcount} == {f_qty[14:0], 1'b0});
    wire wlen_good = ({2'b00, rx_len} == ({f_bcount} + 8'(ssrr_pkg::WRITE_OVERHEAD)));
    wire rlen_good = (rx_len == ssrr_pkg::READ_FRAME);
    wire data_bad = is_write ? !(qty_good && bcount_good && wlen_good)
                             : !(qty_good && rlen_good);
    // Error code follows the first failed check
    wire [7:0] next_err = !(is_write || is_read) ? ssrr_pkg::EC_FUNC :
                          data_bad ? ssrr_pkg::EC_DATA : ssrr_pkg::EC_ADDR;
    wire cmd_bad = !(is_write || is_read) || data_bad || !range_good;

    // Write walk addressing: word k takes bytes 7+2k (high) then 8+2k (low)
    wire [3:0] wr_reg = f_start[3:0] + wr_idx[3:0];
    wire [5:0] wr_pos = ssrr_pkg::POS_WDATA + {wr_idx, 1'b0};
    wire [15:0] wr_word = {rx_buf[wr_pos], rx_buf[wr_pos + 6'h01]};
    wire wr_allowed = ssrr_pkg::WRITABLE_MASK[wr_reg];
    wire wr_last = ({11'h000, wr_idx} == f_qty - 16'h0001);

    // Answer byte selection
    // Two bytes per read word
    wire [5:0] rd_off = tx_idx - ssrr_pkg::POS_RDATA;
    wire [3:0] rd_reg = f_start[3:0] + rd_off[4:1];
    wire [15:0] rd_word = ref_mem[rd_reg];
    wire [7:0] rd_byte = rd_off[0] ? rd_word[7:0] : rd_word[15:8];
    logic [7:0] body_byte;
    wire in_body = (tx_idx < ans_len);
    wire in_crc_lo = (tx_idx == ans_len);
    wire ans_done = (tx_idx == ans_len + ssrr_pkg::LEN_CRC);
    wire send_slot = !tx_valid || tx_ready;
    wire [7:0] next_tx = in_body ? body_byte : in_crc_lo ? tx_crc[7:0] : tx_crc[15:8];

    // Body byte of each answer kind
    always_comb begin
        body_byte = f_addr;
        case (ans_kind)
            // Echo of address, function, start and quantity
            ssrr_pkg::ANS_WRITE: begin
                body_byte = rx_buf[tx_idx];
            end
            // Address, function, byte count, then words
            ssrr_pkg::ANS_READ: begin
                if (tx_idx == ssrr_pkg::POS_RDATA - 6'h01) begin
                    body_byte = {f_qty[6:0], 1'b0};
                end else if (tx_idx < ssrr_pkg::POS_RDATA) begin
                    body_byte = rx_buf[tx_idx];
                end else begin
                    body_byte = rd_byte;
                end
            end
            // Address, function with top bit, error code
            ssrr_pkg::ANS_ERR: begin
                if (tx_idx == ssrr_pkg::POS_FUNC) begin
                    body_byte = f_func | ssrr_pkg::FUNC_ERR_BIT;
                end else if (tx_idx == ssrr_pkg::POS_START_HI) begin
                    body_byte = err_code;
                end else begin
                    body_byte = f_addr;
                end
            end
            default: begin
                body_byte = f_addr;
            end
        endcase
    end

    // Receive capture; bytes arriving while a frame is handled are ignored
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_len <= 6'h00;
            rx_overflow <= 1'b0;
            rx_crc <= ssrr_pkg::CRC_INIT;
        end else if (clk_en) begin
            if (state == ssrr_pkg::ST_IDLE && rx_valid) begin
                if (rx_len < 6'(ssrr_pkg::MAX_FRAME)) begin
                    rx_len <= rx_len + 6'h01;
                end else begin
                    rx_overflow <= 1'b1;                                  // Too long, drop
                end
                rx_crc <= crc_step(rx_crc, rx_data);
            end else if (state == ssrr_pkg::ST_CHECK) begin
                // Fresh start for the next frame, CRC from all ones
                rx_len <= 6'h00;
                rx_overflow <= 1'b0;
                rx_crc <= ssrr_pkg::CRC_INIT;
            end
        end
    end

    // Length limit guards the store
    // Frame byte store; no reset needed on the data path
    always_ff @(posedge clk) begin
        if (clk_en && state == ssrr_pkg::ST_IDLE && rx_valid
                && rx_len < 6'(ssrr_pkg::MAX_FRAME)) begin
            rx_buf[rx_len] <= rx_data;
        end
    end

    // Frame handling sequence
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ssrr_pkg::ST_IDLE;
            ans_kind <= ssrr_pkg::ANS_WRITE;
            ans_len <= 6'h00;
            err_code <= 8'h00;
            wr_idx <= 5'h00;
            bcast <= 1'b0;
        end else if (clk_en) begin
            case (state)
                // Gather bytes until the gap marks the frame end
                ssrr_pkg::ST_IDLE: begin
                    if (rx_frame_end && rx_len != 6'h00) begin
                        state <= ssrr_pkg::ST_CHECK;
                    end
                end
                // Judge the frame; bad CRC or foreign address is silent
                ssrr_pkg::ST_CHECK: begin
                    bcast <= addr_bcast;
                    wr_idx <= 5'h00;
                    err_code <= next_err;
                    if (!frame_good || !addressed) begin
                        state <= ssrr_pkg::ST_IDLE;
                    end else if (cmd_bad) begin
                        ans_kind <= ssrr_pkg::ANS_ERR;
                        ans_len <= ssrr_pkg::LEN_ERR_ANS;
                        state <= addr_bcast ? ssrr_pkg::ST_IDLE : ssrr_pkg::ST_RESP;
                    end else if (is_write) begin
                        ans_kind <= ssrr_pkg::ANS_WRITE;
                        ans_len <= ssrr_pkg::LEN_WRITE_ANS;
                        state <= ssrr_pkg::ST_WRITE;
                    end else begin
                        ans_kind <= ssrr_pkg::ANS_READ;
                        ans_len <= ssrr_pkg::LEN_READ_HDR + {f_qty[4:0], 1'b0};
                        state <= addr_bcast ? ssrr_pkg::ST_IDLE : ssrr_pkg::ST_RESP;
                    end
                end
                // One word per cycle into consecutive registers
                ssrr_pkg::ST_WRITE: begin
                    wr_idx <= wr_idx + 5'h01;
                    if (wr_last) begin
                        state <= bcast ? ssrr_pkg::ST_IDLE : ssrr_pkg::ST_RESP;
                    end
                end
                // Answer bytes go out under the transmitter's ready
                ssrr_pkg::ST_RESP: begin
                    if (send_slot && ans_done) begin
                        state <= ssrr_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= ssrr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Reset clears every word
    // Reference word store; unused addresses never take data
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < ssrr_pkg::REG_COUNT; i++) begin
                ref_mem[i] <= ssrr_pkg::REG_RESET;
            end
        end else if (clk_en && state == ssrr_pkg::ST_WRITE && wr_allowed) begin
            ref_mem[wr_reg] <= wr_word;
        end
    end

    // CRC bytes never feed the CRC
    // Transmit side: one byte held until the transmitter takes it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_data <= 8'h00;
            tx_valid <= 1'b0;
            tx_idx <= 6'h00;
            tx_crc <= ssrr_pkg::CRC_INIT;
        end else if (clk_en) begin
            if (state == ssrr_pkg::ST_RESP && send_slot) begin
                if (ans_done) begin
                    tx_valid <= 1'b0;
                end else begin
                    tx_data <= next_tx;
                    tx_valid <= 1'b1;
                    tx_idx <= tx_idx + 6'h01;
                    if (in_body) begin
                        tx_crc <= crc_step(tx_crc, next_tx);
                    end
                end
            end else if (state != ssrr_pkg::ST_RESP) begin
                tx_idx <= 6'h00;
                tx_crc <= ssrr_pkg::CRC_INIT;
            end
        end
    end

    // Decode of the stored words into drive controls
    wire [15:0] run_w = ref_mem[ssrr_pkg::REG_RUN_CMD];
    wire [15:0] dout_w = ref_mem[ssrr_pkg::REG_DOUT];
    wire [15:0] sel_w = ref_mem[ssrr_pkg::REG_REF_SELECT];
    wire signed [15:0] aout1_w =
        ref_mem[ssrr_pkg::REG_AOUT_ONE];
    wire signed [15:0] aout2_w =
        ref_mem[ssrr_pkg::REG_AOUT_TWO];

    // Counts beyond full scale are held at full scale, so the DAC never wraps
    function automatic logic signed [15:0] clamp_fs(input logic signed [15:0] v);
        if (v > ssrr_pkg::AOUT_FULL_SCALE) begin
            return ssrr_pkg::AOUT_FULL_SCALE;
        end else if (v < -ssrr_pkg::AOUT_FULL_SCALE) begin
            return -ssrr_pkg::AOUT_FULL_SCALE;
        end
        return v;
    endfunction : clamp_fs

    // Next output flop values
    ssrr_pkg::ssrr_ref_out_s next_ref_out;
    always_comb begin
        next_ref_out.fwd_run = run_w[ssrr_pkg::RUN_FWD_BIT];
        next_ref_out.rev_run = run_w[ssrr_pkg::RUN_REV_BIT];
        next_ref_out.remote_external_fault = run_w[ssrr_pkg::RUN_EXT_FAULT_BIT];
        next_ref_out.fault_reset = run_w[ssrr_pkg::RUN_FAULT_RESET_BIT];
        next_ref_out.network_reference_select = run_w[ssrr_pkg::RUN_NET_REF_BIT];
        next_ref_out.comm_control_select = run_w[ssrr_pkg::RUN_COMM_CTRL_BIT];
        next_ref_out.mf_input_cmd = run_w[ssrr_pkg::RUN_MF_HI:ssrr_pkg::RUN_MF_LO];
        // Scaling is applied downstream by the display unit setting
        next_ref_out.speed_reference = ref_mem[ssrr_pkg::REG_SPEED_REF];
        next_ref_out.loop_target_value = ref_mem[ssrr_pkg::REG_LOOP_TARGET];
        next_ref_out.loop_target_enable = sel_w[ssrr_pkg::SEL_LOOP_TARGET_BIT];
        next_ref_out.analog_out_one = clamp_fs(aout1_w);
        next_ref_out.analog_out_two = clamp_fs(aout2_w);
        next_ref_out.relay_contact_output = dout_w[ssrr_pkg::DOUT_RELAY_BIT];
        next_ref_out.photocoupler_output =
            dout_w[ssrr_pkg::DOUT_OPTO_HI:ssrr_pkg::DOUT_OPTO_LO];
        // Fault contact shows the drive's own fault unless the link takes it over
        next_ref_out.fault_relay_contact = dout_w[ssrr_pkg::DOUT_FAULT_EN_BIT]
            ? dout_w[ssrr_pkg::DOUT_FAULT_BIT] : drive_fault;
        next_ref_out.broadcast_enable =
            sel_w[ssrr_pkg::SEL_BCAST_HI:ssrr_pkg::SEL_BCAST_LO];
    end

    // Outputs straight from flops
    // Output flops for controls and status
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_out <= '0;
            busy <= 1'b0;
        end else if (clk_en) begin
            ref_out <= next_ref_out;
            busy <= (state != ssrr_pkg::ST_IDLE);
        end
    end
endmodule : ssrr_core
`default_nettype wire

// [test/ssrr_core_assertions.sv]
`default_nettype none
module ssrr_core_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Link side
    input wire logic [7:0] slave_addr,
    input wire logic rx_frame_end,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_ready,
    // Status and decoded words
    input wire logic busy,
    input wire ssrr_pkg::ssrr_ref_out_s ref_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // An offered byte must not slip while the taker stalls
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("answer byte changed before taken");
    ans_addr_a: assert property ($rose(tx_valid) |-> tx_data == slave_addr)
        else $error("answer does not open with own address");
    ans_func_a: assert property ($rose(tx_valid) && tx_ready |=> tx_valid &&
        (tx_data inside {8'h10, 8'h03} || tx_data[7])) else $error("bad function byte");
    tx_busy_a: assert property (tx_valid |-> busy)
        else $error("answer offered while idle");
    busy_end_a: assert property ($fell(busy) |-> !tx_valid)
        else $error("busy fell with byte pending");
    // The speed reference word changes only as a result of a judged frame
    ref_quiet_a: assert property ($changed(ref_out.speed_reference) |->
        $past(busy) || $past(busy, 2) || $past(busy, 3)) else $error("word changed unprompted");
    clamp_one_a: assert property (ref_out.analog_out_one <= ssrr_pkg::AOUT_FULL_SCALE &&
        ref_out.analog_out_one >= -ssrr_pkg::AOUT_FULL_SCALE) else $error("analog one out of span");
    clamp_two_a: assert property (ref_out.analog_out_two <= ssrr_pkg::AOUT_FULL_SCALE &&
        ref_out.analog_out_two >= -ssrr_pkg::AOUT_FULL_SCALE) else $error("analog two out of span");
    busy_start_a: assert property ($rose(busy) |->
        $past(rx_frame_end) || $past(rx_frame_end, 2) || $past(rx_frame_end, 3))
        else $error("busy without frame end");
    // Main scenarios reached
    cover property ($rose(tx_valid));
    cover property (tx_valid && !tx_ready);
    cover property ($changed(ref_out.fwd_run));
endmodule : ssrr_core_assertions
`default_nettype wire

// [test/ssrr_master_model.sv]
`default_nettype none
module ssrr_master_model (
    // Clock
    input wire logic clk,
    // Command stream into the device
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_frame_end,
    // Taking side of the answer stream
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle link at time zero
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        rx_frame_end = 1'b0;
        tx_ready = 1'b0;
    end
    // Random stalls, so held answer bytes get exercised
    always @(posedge clk) tx_ready <= ($urandom_range(3, 0) != 0);
    // CRC-16 from all ones, reflected polynomial, over every byte given
    function automatic logic [15:0] crc16(input logic [7:0] f[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (f[i]) begin
            c = c ^ {8'h00, f[i]};
            for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        return c;
    endfunction : crc16
    // Sends a frame, check low byte first; bad corrupts the check on purpose
    task automatic send(input logic [7:0] f[$], input logic bad);
        logic [15:0] c;
        c = crc16(f) ^ {15'h0000, bad};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        foreach (f[i]) begin
            @(posedge clk);
            rx_data <= f[i];
            rx_valid <= 1'b1;
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data <= ~f[$]; // Released line shows no stale byte
        rx_frame_end <= 1'b1;
        @(posedge clk);
        rx_frame_end <= 1'b0;
    endtask : send
    // Multi-word write, words high byte first in ascending order
    task automatic write_regs(input logic [7:0] addr, input logic [7:0] start,
        input logic [15:0] w[$], input logic [7:0] bc_skew, input logic bad);
        logic [7:0] f[$];
        f = {addr, 8'h10, 8'h00, start, 8'h00, 8'(w.size()), 8'(2 * w.size()) + bc_skew};
        foreach (w[i]) f = {f, w[i][15:8], w[i][7:0]};
        send(f, bad);
    endtask : write_regs
endmodule : ssrr_master_model
`default_nettype wire

// [test/tb_serial_slave_reference_registers.sv]
`default_nettype none
module tb_serial_slave_reference_registers;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, clk_en, drive_fault, rx_valid, rx_frame_end, tx_valid, tx_ready, busy;
    logic [7:0] slave_addr, rx_data, tx_data;
    ssrr_pkg::ssrr_ref_out_s ref_out;
    logic [7:0] exp_q[$]; // Answer bytes still owed by the device
    int errors, n_checks, cycles;
    ssrr_core uut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .slave_addr(slave_addr),
        .drive_fault(drive_fault), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_frame_end(rx_frame_end), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .busy(busy), .ref_out(ref_out));
    ssrr_master_model m (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_frame_end(rx_frame_end), .tx_ready(tx_ready));
    // 10 ns clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    // Hang guard, far above the several hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end
    // Every taken byte must be the oldest one owed; an unowed byte never matches
    always @(posedge clk) if (rst_b && tx_valid && tx_ready)
        check(16'(tx_data), exp_q.size() ? 16'(exp_q.pop_front()) : 16'hFFFF);
    // Owe an answer with its check bytes appended
    task automatic note(input logic [7:0] f[$]);
        logic [15:0] c;
        c = m.crc16(f);
        exp_q = {exp_q, f, c[7:0], c[15:8]};
    endtask : note
    // Wait out the frame; nothing may stay owed
    task automatic finish_op();
        repeat (3) @(posedge clk);
        for (int i = 0; i < 300 && busy !== 1'b0; i++) @(negedge clk);
        check({15'h0000, busy}, 16'h0000);
        check(16'(exp_q.size()), 16'h0000);
    endtask : finish_op
    task automatic wr(input logic [7:0] start, input logic [15:0] w[$]);
        note({8'h01, 8'h10, 8'h00, start, 8'h00, 8'(w.size())});
        m.write_regs(8'h01, start, w, 8'h00, 1'b0);
        finish_op();
    endtask : wr
    task automatic rd(input logic [7:0] start, input logic [15:0] w[$]);
        logic [7:0] f[$];
        f = {8'h01, 8'h03, 8'(2 * w.size())};
        foreach (w[i]) f = {f, w[i][15:8], w[i][7:0]};
        note(f);
        m.send({8'h01, 8'h03, 8'h00, start, 8'h00, 8'(w.size())}, 1'b0);
        finish_op();
    endtask : rd
    // Test sequence
    initial begin
        logic [15:0] r, d, z[$];
        clk_en = 1'b1;
        slave_addr = 8'h01;
        rst_b = 1'b0;
        drive_fault = 1'b0;
        void'($urandom(11));
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (15) z.push_back(16'h0000);
        rd(8'h01, z); // Words 1 to 15 start cleared
        wr(8'h01, {16'h0001, 16'h0258});
        check({ref_out.rev_run, ref_out.fwd_run}, 16'h0001);
        check(ref_out.speed_reference, 16'h0258);
        for (int i = 0; i < 4; i++) begin
            r = 16'($urandom);
            d = 16'($urandom) & 16'h00DF; // Unused bits left zero
            @(posedge clk);
            drive_fault <= 1'($urandom);
            wr(8'h01, {r});
            wr(8'h09, {d});
            check({ref_out.mf_input_cmd, ref_out.comm_control_select,
                ref_out.network_reference_select, ref_out.fault_reset,
                ref_out.remote_external_fault, ref_out.rev_run, ref_out.fwd_run}, r);
            check({10'h000, ref_out.fault_relay_contact, ref_out.photocoupler_output,
                ref_out.relay_contact_output}, {10'h000, d[6] ? d[7] : drive_fault, d[4:0]});
        end
        wr(8'h06, {16'h1357, 16'h07D0, 16'hF830});
        wr(8'h0F, {16'hF002});
        check(ref_out.loop_target_value, 16'h1357);
        check({ref_out.analog_out_one}, 16'h0604);
        check({ref_out.analog_out_two}, 16'hF9FC);
        check({11'h000, ref_out.broadcast_enable, ref_out.loop_target_enable}, 16'h001F);
        note({8'h01, 8'h90, 8'h03});
        m.write_regs(8'h01, 8'h02, {16'h0BAD}, 8'h01, 1'b0);
        finish_op();
        note({8'h01, 8'h90, 8'h02});
        m.write_regs(8'h01, 8'h0F, {16'h0001, 16'h0002}, 8'h00, 1'b0);
        finish_op();
        m.write_regs(8'h00, 8'h02, {16'h1234}, 8'h00, 1'b0);
        finish_op();
        check(ref_out.speed_reference, 16'h1234);
        m.write_regs(8'h05, 8'h02, {16'h4321}, 8'h00, 1'b0); // Foreign address
        finish_op();
        m.write_regs(8'h01, 8'h02, {16'h4321}, 8'h00, 1'b1);
        finish_op();
        check(ref_out.speed_reference, 16'h1234);
        note({8'h01, 8'h88, 8'h01});
        m.send({8'h01, 8'h08, 8'h00, 8'h00, 8'hA5, 8'h37}, 1'b0);
        finish_op();
        rd(8'h02, {16'h1234, 16'h0000, 16'h0000, 16'h0000, 16'h1357});
        final_report();
    end
endmodule : tb_serial_slave_reference_registers
bind ssrr_core ssrr_core_assertions chk (.clk(clk), .rst_b(rst_b), .slave_addr(slave_addr),
    .rx_frame_end(rx_frame_end), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .busy(busy), .ref_out(ref_out));
`default_nettype wire
